/* src/cfg_regs_pkg.sv */
// constants, field positions and types for the configuration register bank
package cfg_regs_pkg;
  // register indices written through the index port
  localparam logic [7:0] IDX_UART_IR = 8'h0c;
  localparam logic [7:0] IDX_IR_MODE = 8'h0d;
  localparam logic [7:0] IDX_TEST_A = 8'h0e;
  localparam logic [7:0] IDX_TEST_B = 8'h0f;
  localparam logic [7:0] IDX_GP0_LO = 8'h10;
  localparam logic [7:0] IDX_GP0_HI = 8'h11;
  localparam logic [7:0] IDX_GP1_LO = 8'h12;
  localparam logic [7:0] IDX_GP1_HI = 8'h13;
  localparam logic [7:0] IDX_GP0_MODE = 8'h14;
  // host i/o addresses of the three access ports and the two unlock key values
  localparam logic [10:0] UNLOCK_ADDR = 11'h250;
  localparam logic [10:0] INDEX_ADDR = 11'h251;
  localparam logic [10:0] DATA_ADDR = 11'h252;
  localparam logic [7:0] KEY_LOW = 8'h88;
  localparam logic [7:0] KEY_HIGH = 8'h89;
  // values after reset and write masks; strap bits are loaded one edge later
  localparam logic [7:0] RST_UART_IR = 8'h00;
  localparam logic [7:0] RST_IR_MODE = 8'h03;
  localparam logic [7:0] RST_GP = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] UART_IR_WMASK = 8'hef;
  localparam logic [7:0] GP_HI_WMASK = 8'hc7;
  // bit and field positions
  localparam int B_FAST_A = 7;
  localparam int B_FAST_B = 6;
  localparam int B_KEY_SEL = 5;
  localparam int B_IR_SEL = 3;
  localparam int B_GIO_SEL = 2;
  localparam int B_RX_INV = 1;
  localparam int B_TX_INV = 0;
  localparam int F_TXSEL = 6;
  localparam int F_RXSEL = 4;
  localparam int B_DUPLEX = 3;
  localparam int F_IRMODE = 0;
  localparam int F_DW = 6;
  localparam int F_AHI = 0;
  localparam int F_GPM = 5;
  localparam int B_CS_POL = 4;
  localparam int B_Q_RD = 3;
  localparam int B_Q_WR = 2;
  localparam int B_W_INV = 1;
  localparam int B_R_INV = 0;
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_NS = 1600;
  localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
  localparam int CARRIER_HZ = 500000;
  localparam int CARRIER_HALF_CYC = CLK_HZ / (2 * CARRIER_HZ);
  localparam int UART_DIV = 13;
  localparam int SIR_SHORT_TICKS = 3;
  localparam int SIR_HOLD_TICKS = 16;
  localparam int ASK_HOLD_CYC = 4 * CARRIER_HALF_CYC;
  // infrared and general pin mode codes
  localparam logic [2:0] IRM_SIR_FIXED = 3'h2;
  localparam logic [2:0] IRM_SIR_RATIO = 3'h3;
  localparam logic [2:0] IRM_ASK = 3'h4;
  localparam logic [2:0] IRM_ASK_CAR = 3'h5;
  localparam logic [2:0] GPM_OUT = 3'h1;
  localparam logic [2:0] GPM_IN = 3'h2;
  localparam logic [2:0] GPM_IO = 3'h3;
  typedef enum logic {CFG_LOCKED, CFG_OPEN} access_state_t;
endpackage : cfg_regs_pkg

/* src/gp_pin_if.sv */
// carrier between the register bank and one general purpose pin unit
`timescale 1ns/100ps
`default_nettype none
interface gp_pin_if;
  logic [10:0] match_addr;
  logic [1:0] decode_width;
  logic [7:0] mode_bits;
  logic pin_enable;
  logic [10:0] sa;
  logic aen;
  logic ior_n;
  logic iow_n;
  logic sd0;
  logic rd_hit;
  logic rd_bit;
  modport src (
    output match_addr, decode_width, mode_bits, pin_enable, sa, aen, ior_n, iow_n, sd0,
    input rd_hit, rd_bit
  );
  modport unit (
    input match_addr, decode_width, mode_bits, pin_enable, sa, aen, ior_n, iow_n, sd0,
    output rd_hit, rd_bit
  );
endinterface : gp_pin_if
`default_nettype wire

/* src/gp_pin_unit.sv */
// one general purpose pin: address decode, data port or chip select
`timescale 1ns/100ps
`default_nettype none
module gp_pin_unit
  import cfg_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  gp_pin_if.unit cfg,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n
);
  typedef struct packed {
    logic pin_o;
    logic pin_oe_n;
    logic rd_hit;
    logic rd_bit;
  } unit_state_t;
  unit_state_t q;
  unit_state_t s;
  logic [10:0] mask;
  logic match;
  logic rd_cyc;
  logic wr_cyc;
  logic cs_act;
  logic [2:0] mode;

  always_comb begin
    s = q;
    mode = cfg.mode_bits[F_GPM +: 3];
    mask = 11'h7ff << cfg.decode_width;
    match = ((cfg.sa ^ cfg.match_addr) & mask) == 11'h000;
    rd_cyc = match & ~cfg.aen & ~cfg.ior_n;
    wr_cyc = match & ~cfg.aen & ~cfg.iow_n;
    unique case ({cfg.mode_bits[B_Q_RD], cfg.mode_bits[B_Q_WR]})
      2'b00: cs_act = match & ~cfg.aen;
      2'b01: cs_act = wr_cyc;
      2'b10: cs_act = rd_cyc;
      2'b11: cs_act = rd_cyc | wr_cyc;
    endcase
    s.rd_hit = 1'b0;
    s.rd_bit = 1'b0;
    s.pin_oe_n = 1'b1;
    if (cfg.pin_enable && mode[2]) begin
      s.pin_oe_n = 1'b0;
      s.pin_o = cfg.mode_bits[B_CS_POL] ? cs_act : ~cs_act;
    end else if (cfg.pin_enable) begin
      if (mode == GPM_OUT || mode == GPM_IO) begin
        s.pin_oe_n = 1'b0;
        if (wr_cyc) begin
          s.pin_o = cfg.sd0 ^ cfg.mode_bits[B_W_INV];
        end
      end
      // pin level onto data bit 0
      if (mode == GPM_IN || mode == GPM_IO) begin
        s.rd_hit = rd_cyc;
        s.rd_bit = pin_i ^ cfg.mode_bits[B_R_INV];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{pin_o: 1'b0, pin_oe_n: 1'b1, rd_hit: 1'b0, rd_bit: 1'b0};
    end else begin
      q <= s;
    end
  end

  assign pin_o = q.pin_o;
  assign pin_oe_n = q.pin_oe_n;
  assign cfg.rd_hit = q.rd_hit;
  assign cfg.rd_bit = q.rd_bit;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_cs_active_level: assert property (
    (cfg.pin_enable && mode[2] && cs_act) |=> (pin_o == $past(cfg.mode_bits[B_CS_POL]))
  ) else $error("chip select level wrong on qualified cycle");

  a_out_latch_hold: assert property (
    (cfg.pin_enable && (mode == GPM_OUT || mode == GPM_IO) && !wr_cyc && !pin_oe_n) ##1
      (cfg.pin_enable && (mode == GPM_OUT || mode == GPM_IO) && !wr_cyc) |=> $stable(pin_o)
  ) else $error("output port changed without a write");
endmodule : gp_pin_unit
`default_nettype wire

/* src/cfg_reg_bank.sv */
// indexed configuration register bank for uart clocks, infrared and general pins
`timescale 1ns/100ps
`default_nettype none
module cfg_reg_bank
  import cfg_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [10:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [7:0] sd_in,
  output logic [7:0] sd_out,
  output logic sd_oe_n,
  input wire logic key_strap_pin,
  input wire logic infrared_strap_pin,
  input wire logic general_io_strap_pin,
  output logic general_io_function_select,
  output logic uart_a_clk_tick,
  output logic uart_b_clk_tick,
  input wire logic uart_b_baud16_tick,
  input wire logic uart_b_core_sout,
  output logic uart_b_core_sin,
  output logic [2:0] ir_tx_pin_o,
  output logic [2:0] ir_tx_pin_oe_n,
  input wire logic [3:0] ir_rx_pin_i,
  input wire logic [1:0] general_pin_i,
  output logic [1:0] general_pin_o,
  output logic [1:0] general_pin_oe_n
);
  typedef struct packed {
    access_state_t acc;
    logic [7:0] index;
    logic iow_q;
    logic strap_done;
    logic [7:0] uart_ir;
    logic [7:0] ir_mode;
    logic [7:0] gp0_lo;
    logic [7:0] gp0_hi;
    logic [7:0] gp1_lo;
    logic [7:0] gp1_hi;
    logic [7:0] gp0_mode;
    logic [7:0] sd_out;
    logic sd_oe_n;
    logic [3:0] div13;
    logic tick_a;
    logic tick_b;
    logic sout_q;
    logic [6:0] pulse_cnt;
    logic [5:0] car_cnt;
    logic carrier;
    logic [7:0] demod_cnt;
    logic sin;
    logic [2:0] tx_o;
    logic [2:0] tx_oe_n;
  } bank_state_t;

  bank_state_t q;
  bank_state_t s;
  logic wr_edge;
  logic rd_cyc;
  logic [7:0] key;
  logic [7:0] rd_val;
  logic div_end;
  logic [2:0] irm;
  logic ir_on;
  logic ir_active;
  logic sir;
  logic tx_start;
  logic tx_level;
  logic rx_raw;
  logic rx_busy;
  logic [1:0] txsel;
  logic [1:0] rxsel;
  logic [1:0] gp_rd_hit;
  logic [1:0] gp_rd_bit;
  logic [1:0][7:0] addr_lo;
  logic [1:0][7:0] addr_hi;
  logic [1:0][7:0] mode_w;

  always_comb begin
    s = q;
    s.iow_q = iow_n;
    // a write is taken once, on the falling edge of the write strobe
    wr_edge = q.iow_q & ~iow_n & ~aen;
    rd_cyc = ~ior_n & ~aen;
    key = q.uart_ir[B_KEY_SEL] ? KEY_HIGH : KEY_LOW;

    if (!q.strap_done) begin
      s.strap_done = 1'b1;
      s.uart_ir[B_KEY_SEL] = key_strap_pin;
      s.uart_ir[B_IR_SEL] = infrared_strap_pin;
      s.uart_ir[B_GIO_SEL] = general_io_strap_pin;
    end

    if (wr_edge && sa == UNLOCK_ADDR) begin
      s.acc = (sd_in == key) ? CFG_OPEN : CFG_LOCKED;
    end else if (wr_edge && q.acc == CFG_OPEN && sa == INDEX_ADDR) begin
      s.index = sd_in;
    end else if (wr_edge && q.acc == CFG_OPEN && sa == DATA_ADDR) begin
      case (q.index)
        IDX_UART_IR: s.uart_ir = sd_in & UART_IR_WMASK;
        IDX_IR_MODE: s.ir_mode = sd_in;
        IDX_GP0_LO: s.gp0_lo = sd_in;
        IDX_GP0_HI: s.gp0_hi = sd_in & GP_HI_WMASK;
        IDX_GP1_LO: s.gp1_lo = sd_in;
        IDX_GP1_HI: s.gp1_hi = sd_in & GP_HI_WMASK;
        IDX_GP0_MODE: s.gp0_mode = sd_in;
        default: s.index = q.index;
      endcase
    end

    case (q.index)
      IDX_UART_IR: rd_val = q.uart_ir;
      IDX_IR_MODE: rd_val = q.ir_mode;
      IDX_GP0_LO: rd_val = q.gp0_lo;
      IDX_GP0_HI: rd_val = q.gp0_hi;
      IDX_GP1_LO: rd_val = q.gp1_lo;
      IDX_GP1_HI: rd_val = q.gp1_hi;
      IDX_GP0_MODE: rd_val = q.gp0_mode;
      default: rd_val = 8'h00;
    endcase

    s.sd_out = 8'h00;
    s.sd_oe_n = 1'b1;
    if (rd_cyc && q.acc == CFG_OPEN && sa == DATA_ADDR) begin
      s.sd_out = rd_val;
      s.sd_oe_n = 1'b0;
    end else if (rd_cyc && q.acc == CFG_OPEN && sa == INDEX_ADDR) begin
      s.sd_out = q.index;
      s.sd_oe_n = 1'b0;
    end else if (|gp_rd_hit) begin
      // only data bit 0 carries the pin
      s.sd_out = {7'h00, |(gp_rd_hit & gp_rd_bit)};
      s.sd_oe_n = 1'b0;
    end

    // divide by 13 or pass through
    div_end = q.div13 == 4'(UART_DIV - 1);
    s.div13 = div_end ? 4'h0 : q.div13 + 4'h1;
    s.tick_a = q.uart_ir[B_FAST_A] | div_end;
    s.tick_b = q.uart_ir[B_FAST_B] | div_end;

    // carrier toggles every half period
    if (q.car_cnt == 6'(CARRIER_HALF_CYC - 1)) begin
      s.car_cnt = 6'h00;
      s.carrier = ~q.carrier;
    end else begin
      s.car_cnt = q.car_cnt + 6'h01;
    end

    ir_on = ~q.uart_ir[B_IR_SEL];
    irm = q.ir_mode[F_IRMODE +: 3];
    ir_active = ir_on & (irm[2:1] != 2'b00);
    sir = irm[2:1] == 2'b01;
    txsel = q.ir_mode[F_TXSEL +: 2];
    rxsel = q.ir_mode[F_RXSEL +: 2];

    // a pulse starts at each falling edge of the serial output
    s.sout_q = uart_b_core_sout;
    tx_start = q.sout_q & ~uart_b_core_sout;
    if (tx_start && sir) begin
      s.pulse_cnt = (irm == IRM_SIR_FIXED) ? 7'(PULSE_CYC) : 7'(SIR_SHORT_TICKS);
    end else if (q.pulse_cnt != 7'h00 && (irm == IRM_SIR_FIXED || uart_b_baud16_tick)) begin
      s.pulse_cnt = q.pulse_cnt - 7'h01;
    end

    // keyed modes invert, odd codes gate carrier
    if (sir) begin
      tx_level = q.pulse_cnt != 7'h00;
    end else begin
      tx_level = ~uart_b_core_sout & (~irm[0] | q.carrier);
    end

    tx_level = tx_level ^ q.uart_ir[B_TX_INV];
    s.tx_oe_n = 3'b111;
    s.tx_o = 3'b000;
    if (!ir_on) begin
      s.tx_oe_n[1] = 1'b0;
      s.tx_o[1] = uart_b_core_sout ^ q.uart_ir[B_TX_INV];
    end else if (ir_active) begin
      unique case (txsel)
        2'b01: begin
          s.tx_oe_n[1] = 1'b0;
          s.tx_o[1] = tx_level;
        end
        2'b10: begin
          s.tx_oe_n[2] = 1'b0;
          s.tx_o[2] = tx_level;
        end
        2'b00, 2'b11: begin
          s.tx_oe_n[0] = 1'b0;
          s.tx_o[0] = tx_level;
        end
      endcase
    end

    rx_raw = ir_rx_pin_i[rxsel] ^ q.uart_ir[B_RX_INV];
    // half duplex blinds receive while sending
    rx_busy = q.ir_mode[B_DUPLEX] & (~uart_b_core_sout | (q.pulse_cnt != 7'h00));

    // demodulator: a low on the receive line restarts the hold window
    if (!rx_raw) begin
      s.demod_cnt = sir ? 8'(SIR_HOLD_TICKS) : 8'(ASK_HOLD_CYC);
    end else if (q.demod_cnt != 8'h00 && (!sir || uart_b_baud16_tick)) begin
      s.demod_cnt = q.demod_cnt - 8'h01;
    end

    if (!ir_on) begin
      s.sin = ir_rx_pin_i[1] ^ q.uart_ir[B_RX_INV];
    end else if (!ir_active || rx_busy) begin
      s.sin = 1'b1;
    end else if (irm == IRM_ASK || irm == IRM_ASK_CAR) begin
      s.sin = rx_raw;
    end else begin
      s.sin = q.demod_cnt == 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{acc: CFG_LOCKED, index: RST_INDEX, iow_q: 1'b1, strap_done: 1'b0,
             uart_ir: RST_UART_IR, ir_mode: RST_IR_MODE, gp0_lo: RST_GP, gp0_hi: RST_GP,
             gp1_lo: RST_GP, gp1_hi: RST_GP, gp0_mode: RST_GP, sd_out: 8'h00,
             sd_oe_n: 1'b1, div13: 4'h0, tick_a: 1'b0, tick_b: 1'b0, sout_q: 1'b1,
             pulse_cnt: 7'h00, car_cnt: 6'h00, carrier: 1'b0, demod_cnt: 8'h00,
             sin: 1'b1, tx_o: 3'b000, tx_oe_n: 3'b111};
    end else begin
      q <= s;
    end
  end

  assign sd_out = q.sd_out;
  assign sd_oe_n = q.sd_oe_n;
  assign general_io_function_select = q.uart_ir[B_GIO_SEL];
  assign uart_a_clk_tick = q.tick_a;
  assign uart_b_clk_tick = q.tick_b;
  assign uart_b_core_sin = q.sin;
  assign ir_tx_pin_o = q.tx_o;
  assign ir_tx_pin_oe_n = q.tx_oe_n;

  // second pin has no mode register in this bank, so it stays floating
  assign addr_lo = {q.gp1_lo, q.gp0_lo};
  assign addr_hi = {q.gp1_hi, q.gp0_hi};
  assign mode_w = {8'h00, q.gp0_mode};

  gp_pin_if gp_if [2] ();

  for (genvar i = 0; i < 2; i++) begin : g_pin
    // address bits 10 to 8 from the high register
    assign gp_if[i].match_addr = {addr_hi[i][F_AHI +: 3], addr_lo[i]};
    assign gp_if[i].decode_width = addr_hi[i][F_DW +: 2];
    assign gp_if[i].mode_bits = mode_w[i];
    assign gp_if[i].pin_enable = q.uart_ir[B_GIO_SEL];
    assign gp_if[i].sa = sa;
    assign gp_if[i].aen = aen;
    assign gp_if[i].ior_n = ior_n;
    assign gp_if[i].iow_n = iow_n;
    assign gp_if[i].sd0 = sd_in[0];
    assign gp_rd_hit[i] = gp_if[i].rd_hit;
    assign gp_rd_bit[i] = gp_if[i].rd_bit;
    gp_pin_unit u_pin (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .cfg(gp_if[i]),
      .pin_i(general_pin_i[i]),
      .pin_o(general_pin_o[i]),
      .pin_oe_n(general_pin_oe_n[i])
    );
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_uart_a_divide: assert property (
    !q.uart_ir[B_FAST_A] |=> (uart_a_clk_tick == ($past(q.div13) == 4'hc))
  ) else $error("uart a tick not at divide by 13");

  a_uart_b_fast: assert property (
    q.uart_ir[B_FAST_B] |=> uart_b_clk_tick
  ) else $error("uart b fast clock missing a tick");

  a_key_opens: assert property (
    (wr_edge && sa == UNLOCK_ADDR && sd_in == 8'h88 && !q.uart_ir[B_KEY_SEL])
      |=> q.acc == CFG_OPEN ##1 q.acc == CFG_OPEN || $past(wr_edge)
  ) else $error("key 88h did not open access");

  a_strap_key: assert property (
    $rose(q.strap_done) |-> q.uart_ir[B_KEY_SEL] == $past(key_strap_pin)
  ) else $error("key select not taken from strap");

  a_rx_normal_inv: assert property (
    q.uart_ir[B_IR_SEL] |=> uart_b_core_sin == $past(ir_rx_pin_i[1] ^ q.uart_ir[B_RX_INV])
  ) else $error("normal receive path invert wrong");

  a_tx_normal_inv: assert property (
    q.uart_ir[B_IR_SEL] |=> !ir_tx_pin_oe_n[1]
      && ir_tx_pin_o[1] == $past(uart_b_core_sout ^ q.uart_ir[B_TX_INV])
  ) else $error("normal transmit path invert wrong");

  a_tx_route_cs: assert property (
    (ir_active && txsel == 2'b10) |=> ir_tx_pin_oe_n == 3'b011
  ) else $error("transmit not routed to chip select b");

  a_ir_disabled: assert property (
    (ir_on && irm[2:1] == 2'b00) |=> ir_tx_pin_oe_n == 3'b111 && uart_b_core_sin
  ) else $error("disabled infrared not floating and high");

  a_sir_pulse_len: assert property (
    (tx_start && irm == IRM_SIR_FIXED) |=> q.pulse_cnt == 7'h40 ##63 q.pulse_cnt == 7'h01
  ) else $error("fixed infrared pulse length wrong");
endmodule : cfg_reg_bank
`default_nettype wire

/* dv/isa_host_model.sv */
// host bus model that drives the unlock, index and data ports
`timescale 1ns/100ps
`default_nettype none
module isa_host_model
  import cfg_regs_pkg::*;
(
  input wire logic ref_clk,
  output var logic [10:0] sa,
  output var logic aen,
  output var logic ior_n,
  output var logic iow_n,
  output var logic [7:0] sd_in,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe_n
);
  initial begin
    sa = 11'h000;
    aen = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    sd_in = 8'h00;
  end
  // released lines show the inverse so a stale value cannot pass for a hold
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sa = a;
    sd_in = d;
    aen = 1'b0;
    iow_n = 1'b0;
    @(negedge ref_clk);
    iow_n = 1'b1;
    aen = 1'b1;
    sd_in = ~d;
    sa = ~a;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic oe_n);
    @(negedge ref_clk);
    sa = a;
    aen = 1'b0;
    ior_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    d = sd_out;
    oe_n = sd_oe_n;
    ior_n = 1'b1;
    aen = 1'b1;
    sa = ~a;
    @(negedge ref_clk);
  endtask : rd
  // qualified address phase with no strobe at all
  task automatic addr(input logic [10:0] a);
    @(negedge ref_clk);
    sa = a;
    aen = 1'b0;
    repeat (2) @(negedge ref_clk);
    aen = 1'b1;
    sa = ~a;
  endtask : addr
  // index first, then the data port
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    wr(INDEX_ADDR, idx);
    wr(DATA_ADDR, v);
  endtask : cfg_wr
  // index first, then the data port
  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d, output logic oe_n);
    wr(INDEX_ADDR, idx);
    rd(DATA_ADDR, d, oe_n);
  endtask : cfg_rd
endmodule : isa_host_model
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cfg_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n;
  logic [10:0] sa;
  logic aen, ior_n, iow_n, sd_oe_n, gio_sel, tick_a, tick_b, baud16, sout, sin, oe;
  logic [7:0] sd_in, sd_out, d, na, nb;
  logic [2:0] straps, tx_o, tx_oe_n;
  logic [3:0] rx_i;
  logic [1:0] gp_i, gp_o, gp_oe_n;
  int fails = 0;
  int tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  cfg_reg_bank dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .sa(sa), .aen(aen), .ior_n(ior_n),
    .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n),
    .key_strap_pin(straps[0]), .infrared_strap_pin(straps[1]),
    .general_io_strap_pin(straps[2]), .general_io_function_select(gio_sel),
    .uart_a_clk_tick(tick_a), .uart_b_clk_tick(tick_b), .uart_b_baud16_tick(baud16),
    .uart_b_core_sout(sout), .uart_b_core_sin(sin), .ir_tx_pin_o(tx_o),
    .ir_tx_pin_oe_n(tx_oe_n), .ir_rx_pin_i(rx_i), .general_pin_i(gp_i),
    .general_pin_o(gp_o), .general_pin_oe_n(gp_oe_n));
  isa_host_model host_u (.ref_clk(ref_clk), .sa(sa), .aen(aen), .ior_n(ior_n),
    .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic count_ticks(input int n, output logic [7:0] ca, output logic [7:0] cb);
    ca = 8'h00;
    cb = 8'h00;
    repeat (n) begin
      @(negedge ref_clk);
      ca = ca + {7'h00, tick_a};
      cb = cb + {7'h00, tick_b};
    end
  endtask : count_ticks
  task automatic count_high(input int n, input int sel, output logic [7:0] c);
    c = 8'h00;
    repeat (n) begin
      @(negedge ref_clk);
      c = c + {7'h00, tx_o[sel]};
    end
  endtask : count_high
  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask : settle
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    arst_n = 1'b0;
    straps = 3'h7;
    baud16 = 1'b0;
    sout = 1'b1;
    rx_i = 4'hf;
    gp_i = 2'h0;
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({7'h00, gio_sel}, 8'h01);
    // strap pulled high, so the low key must not open the ports
    host_u.wr(UNLOCK_ADDR, KEY_LOW);
    host_u.cfg_rd(IDX_UART_IR, d, oe);
    chk({7'h00, oe}, 8'h01);
    host_u.wr(UNLOCK_ADDR, KEY_HIGH);
    host_u.cfg_rd(IDX_UART_IR, d, oe);
    chk(d, 8'h2c);
    chk({7'h00, oe}, 8'h00);
    host_u.cfg_rd(IDX_IR_MODE, d, oe);
    chk(d, 8'h03);
    host_u.cfg_wr(IDX_UART_IR, 8'hff);
    host_u.cfg_rd(IDX_UART_IR, d, oe);
    chk(d, 8'hef);
    count_ticks(13, na, nb);
    chk(na, 8'h0d);
    chk(nb, 8'h0d);
    host_u.cfg_wr(IDX_UART_IR, 8'h08);
    count_ticks(26, na, nb);
    chk(na, 8'h02);
    chk(nb, 8'h02);
    // key select now 0: the high key relocks, the low key reopens
    host_u.wr(UNLOCK_ADDR, KEY_HIGH);
    host_u.cfg_rd(IDX_UART_IR, d, oe);
    chk({7'h00, oe}, 8'h01);
    host_u.wr(UNLOCK_ADDR, KEY_LOW);
    host_u.cfg_rd(IDX_UART_IR, d, oe);
    chk(d, 8'h08);
    host_u.cfg_wr(IDX_TEST_A, 8'hff);
    host_u.cfg_rd(IDX_TEST_A, d, oe);
    chk(d, 8'h00);
    host_u.cfg_rd(8'h20, d, oe);
    chk(d, 8'h00);
    // general pin: window 0x134..0x137, i/o port with both inverts
    host_u.cfg_wr(IDX_UART_IR, 8'h04);
    host_u.cfg_wr(IDX_GP0_LO, 8'h34);
    host_u.cfg_wr(IDX_GP0_HI, 8'hf9);
    host_u.cfg_rd(IDX_GP0_HI, d, oe);
    chk(d, 8'hc1);
    host_u.cfg_wr(IDX_GP0_HI, 8'h81);
    host_u.cfg_wr(IDX_GP0_MODE, 8'h63);
    host_u.wr(11'h136, 8'h00);
    repeat (4) @(negedge ref_clk);
    chk({5'h00, gp_oe_n[1], gp_o[0], gp_oe_n[0]}, 8'h06);
    host_u.rd(11'h135, d, oe);
    chk(d, 8'h01);
    chk({7'h00, oe}, 8'h00);
    host_u.rd(11'h138, d, oe);
    chk({7'h00, oe}, 8'h01);
    host_u.cfg_wr(IDX_GP0_MODE, 8'h90);
    host_u.addr(11'h134);
    chk({7'h00, gp_o[0]}, 8'h01);
    host_u.addr(11'h13c);
    chk({7'h00, gp_o[0]}, 8'h00);
    host_u.cfg_wr(IDX_GP0_MODE, 8'h94);
    host_u.addr(11'h134);
    chk({7'h00, gp_o[0]}, 8'h00);
    host_u.cfg_wr(IDX_GP0_MODE, 8'h80);
    host_u.addr(11'h134);
    chk({7'h00, gp_o[0]}, 8'h00);
    // infrared keyed mode on the serial output pin
    host_u.cfg_wr(IDX_IR_MODE, 8'h44);
    sout = 1'b0;
    settle();
    chk({5'h00, tx_o}, 8'h02);
    chk({5'h00, tx_oe_n}, 8'h05);
    sout = 1'b1;
    settle();
    chk({5'h00, tx_o}, 8'h00);
    host_u.cfg_wr(IDX_IR_MODE, 8'h24);
    rx_i = 4'hb;
    settle();
    chk({7'h00, sin}, 8'h00);
    rx_i = 4'hf;
    settle();
    chk({7'h00, sin}, 8'h01);
    host_u.cfg_wr(IDX_UART_IR, 8'h06);
    settle();
    chk({7'h00, sin}, 8'h00);
    host_u.cfg_wr(IDX_IR_MODE, 8'h00);
    settle();
    chk({5'h00, tx_oe_n}, 8'h07);
    chk({7'h00, sin}, 8'h01);
    // fixed pulse routed to chip select b
    host_u.cfg_wr(IDX_IR_MODE, 8'h82);
    sout = 1'b0;
    count_high(80, 2, na);
    chk(na, 8'(PULSE_CYC));
    chk({5'h00, tx_oe_n}, 8'h03);
    sout = 1'b1;
    // carrier gated keyed mode on the direction pin
    host_u.cfg_wr(IDX_IR_MODE, 8'h05);
    sout = 1'b0;
    count_high(80, 0, na);
    chk(na, 8'(CARRIER_HALF_CYC));
    sout = 1'b1;
    // half duplex blinds receive while sending
    host_u.cfg_wr(IDX_IR_MODE, 8'h0c);
    sout = 1'b0;
    settle();
    chk({7'h00, sin}, 8'h01);
    sout = 1'b1;
    settle();
    chk({7'h00, sin}, 8'h00);
    // second reset with every strap low
    arst_n = 1'b0;
    straps = 3'h0;
    repeat (2) @(negedge ref_clk);
    chk({6'h00, gp_oe_n}, 8'h03);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({7'h00, gio_sel}, 8'h00);
    host_u.wr(UNLOCK_ADDR, KEY_LOW);
    host_u.cfg_rd(IDX_UART_IR, d, oe);
    chk({7'h00, oe}, 8'h00);
    chk(d, 8'h00);
    stop_test();
  end
endmodule : tb
`default_nettype wire
